// File: src/rmsa_pkg.sv
package rmsa_pkg;
    localparam int RMSA_DATA_W = 32;
    localparam int RMSA_SPRN_W = 10;
    localparam int RMSA_REGION_W = 5;
    // special-purpose register numbers
    localparam logic [9:0] RMSA_SPR_GUARD = 10'h3b9;
    localparam logic [9:0] RMSA_SPR_ENDIAN = 10'h3bb;
    localparam logic [9:0] RMSA_SPR_COMPRESS = 10'h3bc;
    // reset value not given; all regions normal, big-endian, uncompressed
    localparam logic [31:0] RMSA_ATTR_RESET = 32'h0000_0000;
    localparam int RMSA_REGION_LSB = 27;
    localparam int RMSA_REGION_MSB = 31;

    typedef struct packed {
        logic we;
        logic [9:0] sprn;
        logic [31:0] wdata;
    } rmsa_spr_req_t;

    typedef struct packed {
        logic valid;
        logic guarded;
        logic little_endian;
        logic compress;
    } rmsa_attr_t;

    typedef enum logic [0:0] {
        RMSA_READ = 1'b0,
        RMSA_WRITE = 1'b1
    } rmsa_spr_op_t;
endpackage : rmsa_pkg

// File: src/rmsa_region_reg.sv
`timescale 1ns/1ps
module rmsa_region_reg (
    input wire logic clk, // core clock
    input wire logic sys_rst, // async reset, active high
    input wire logic wr_en, // write strobe for this register
    input wire logic [31:0] wdata, // write data
    input wire logic [4:0] region, // selected region index
    output logic [31:0] value_r, // stored register
    output logic bit_sel // bit for the selected region
);
    import rmsa_pkg::*;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            value_r <= RMSA_ATTR_RESET;
        else if (wr_en)
            value_r <= wdata;
    end

    // bits are numbered from the msb, so region 0 (lowest 128 MB) sits in the top bit
    assign bit_sel = value_r[~region]; // R04
endmodule : rmsa_region_reg

// File: src/rmsa_top.sv
// Behaviour
// R01 - guard bit one marks region accesses guarded
// R02 - endian bit one selects little-endian order
// R03 - compress bit one activates storage compression
// R04 - bit n covers region at n*128MB
// R05 - top five address bits pick bit; real mode
`timescale 1ns/1ps
module rmsa_top (
    input wire logic clk, // core clock, 40 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic spr_valid, // spr access strobe
    input wire rmsa_pkg::rmsa_spr_req_t spr_req, // spr number, write flag, data
    output logic spr_ack_r, // access hit one of our registers
    output logic [31:0] spr_rdata_r, // read data, zero on miss
    input wire logic acc_valid, // core presents an address
    input wire logic xlate_en, // address translation enabled
    input wire logic [31:0] acc_addr, // effective address
    output rmsa_pkg::rmsa_attr_t attr_r // attributes for that access
);
    import rmsa_pkg::*;

    logic [4:0] region;
    logic hit_g;
    logic hit_e;
    logic hit_c;
    logic hit_any;
    logic wr;
    logic [31:0] guard_v;
    logic [31:0] endian_v;
    logic [31:0] compress_v;
    logic g_bit;
    logic e_bit;
    logic c_bit;
    logic [31:0] rdata_nxt;
    rmsa_attr_t attr_nxt;

    assign region = acc_addr[RMSA_REGION_MSB:RMSA_REGION_LSB]; // R05
    assign hit_g = spr_req.sprn == RMSA_SPR_GUARD;
    assign hit_e = spr_req.sprn == RMSA_SPR_ENDIAN;
    assign hit_c = spr_req.sprn == RMSA_SPR_COMPRESS;
    assign hit_any = hit_g || hit_e || hit_c;
    assign wr = spr_valid && (spr_req.we == RMSA_WRITE);

    rmsa_region_reg u_guard (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(wr && hit_g),
        .wdata(spr_req.wdata),
        .region(region),
        .value_r(guard_v),
        .bit_sel(g_bit)
    );

    rmsa_region_reg u_endian (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(wr && hit_e),
        .wdata(spr_req.wdata),
        .region(region),
        .value_r(endian_v),
        .bit_sel(e_bit)
    );

    rmsa_region_reg u_compress (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(wr && hit_c),
        .wdata(spr_req.wdata),
        .region(region),
        .value_r(compress_v),
        .bit_sel(c_bit)
    );

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (hit_g)
            rdata_nxt = guard_v;
        else if (hit_e)
            rdata_nxt = endian_v;
        else if (hit_c)
            rdata_nxt = compress_v;
    end

    // only mapped numbers answer, so a stray access never looks like success
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            spr_ack_r <= 1'b0;
        else
            spr_ack_r <= spr_valid && hit_any;
    end

    // writes and idle cycles return zero, so the core never latches stale data
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            spr_rdata_r <= 32'h0000_0000;
        else if (spr_valid && spr_req.we == RMSA_READ)
            spr_rdata_r <= rdata_nxt;
        else
            spr_rdata_r <= 32'h0000_0000;
    end

    // with translation on, the mmu supplies attributes; report none here
    always_comb
    begin
        attr_nxt.valid = acc_valid && !xlate_en; // R05
        attr_nxt.guarded = attr_nxt.valid && g_bit; // R01
        attr_nxt.little_endian = attr_nxt.valid && e_bit; // R02
        attr_nxt.compress = attr_nxt.valid && c_bit; // R03
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            attr_r <= '0;
        else
            attr_r <= attr_nxt;
    end

    // a lookup reports the bit as it stood when the address was taken; region r is bit 31 - r
    chk_guard_follows: assert property (@(posedge clk) disable iff (sys_rst) // R01
        acc_valid && !xlate_en
        |=> attr_r.guarded == $past(guard_v[31 - acc_addr[31:27]]))
        else $error("guarded attribute wrong");

    chk_endian_follows: assert property (@(posedge clk) disable iff (sys_rst) // R02
        acc_valid && !xlate_en
        |=> attr_r.little_endian == $past(endian_v[31 - acc_addr[31:27]]))
        else $error("endian attribute wrong");

    chk_compress_follows: assert property (@(posedge clk) disable iff (sys_rst) // R03
        acc_valid && !xlate_en
        |=> attr_r.compress == $past(compress_v[31 - acc_addr[31:27]]))
        else $error("compress attribute wrong");

    chk_top_region: assert property (@(posedge clk) disable iff (sys_rst) // R04
        acc_valid && !xlate_en && acc_addr[31:27] == 5'h1f
        |=> attr_r.guarded == $past(guard_v[0]))
        else $error("top region maps wrong bit");

    chk_low_region: assert property (@(posedge clk) disable iff (sys_rst) // R04
        acc_valid && !xlate_en && acc_addr[31:27] == 5'h00
        |=> attr_r.little_endian == $past(endian_v[31]))
        else $error("low region maps wrong bit");

    chk_mid_region: assert property (@(posedge clk) disable iff (sys_rst) // R04
        acc_valid && !xlate_en && acc_addr[31:27] == 5'h10
        |=> attr_r.compress == $past(compress_v[15]))
        else $error("middle region maps wrong bit");

    chk_real_valid: assert property (@(posedge clk) disable iff (sys_rst) // R05
        acc_valid && !xlate_en
        |=> attr_r.valid)
        else $error("real mode lookup not reported");

    chk_xlate_quiet: assert property (@(posedge clk) disable iff (sys_rst) // R05
        xlate_en
        |=> attr_r == '0)
        else $error("attributes given under translation");

    chk_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !acc_valid
        |=> attr_r == '0)
        else $error("attributes given without an address");

    chk_write_lands: assert property (@(posedge clk) disable iff (sys_rst) // R01
        spr_valid && spr_req.we && hit_g
        |=> guard_v == $past(spr_req.wdata))
        else $error("guard write lost");

    chk_endian_write: assert property (@(posedge clk) disable iff (sys_rst) // R02
        spr_valid && spr_req.we && hit_e
        |=> endian_v == $past(spr_req.wdata))
        else $error("endian write lost");

    chk_compress_write: assert property (@(posedge clk) disable iff (sys_rst) // R03
        spr_valid && spr_req.we && hit_c
        |=> compress_v == $past(spr_req.wdata))
        else $error("compress write lost");

    chk_miss_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        spr_valid && spr_req.we && !hit_any
        |=> $stable(guard_v) && $stable(endian_v) && $stable(compress_v))
        else $error("unmapped write changed a register");

    chk_hold_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        !(spr_valid && spr_req.we)
        |=> $stable(guard_v) && $stable(endian_v) && $stable(compress_v))
        else $error("register changed without a write");

    chk_guard_readback: assert property (@(posedge clk) disable iff (sys_rst) // R01
        spr_valid && !spr_req.we && hit_g
        |=> spr_rdata_r == $past(guard_v))
        else $error("guard readback wrong");

    chk_endian_readback: assert property (@(posedge clk) disable iff (sys_rst) // R02
        spr_valid && !spr_req.we && hit_e
        |=> spr_rdata_r == $past(endian_v))
        else $error("endian readback wrong");

    chk_readback: assert property (@(posedge clk) disable iff (sys_rst) // R03
        spr_valid && !spr_req.we && hit_c
        |=> spr_rdata_r == $past(compress_v))
        else $error("compress readback wrong");

    chk_miss_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
        spr_valid && !hit_any
        |=> !spr_ack_r && spr_rdata_r == 32'h0000_0000)
        else $error("unmapped access answered");

    chk_write_rdata_zero: assert property (@(posedge clk) disable iff (sys_rst)
        spr_valid && spr_req.we
        |=> spr_rdata_r == 32'h0000_0000)
        else $error("write returned read data");

    chk_ack_mapped: assert property (@(posedge clk) disable iff (sys_rst)
        spr_valid && hit_any
        |=> spr_ack_r)
        else $error("mapped access not acknowledged");

    chk_quiet_bus: assert property (@(posedge clk) disable iff (sys_rst)
        !spr_valid
        |=> !spr_ack_r && spr_rdata_r == 32'h0000_0000)
        else $error("answer without an access");

    cov_guarded: cover property (@(posedge clk) attr_r.valid && attr_r.guarded);
    cov_little: cover property (@(posedge clk) attr_r.valid && attr_r.little_endian);
    cov_compress: cover property (@(posedge clk) attr_r.valid && attr_r.compress);
    cov_write_read: cover property (@(posedge clk) spr_valid && spr_req.we ##1 spr_valid && !spr_req.we);
    cov_miss: cover property (@(posedge clk) spr_valid && !hit_any);
endmodule : rmsa_top

// File: tb/rmsa_core_model.sv
`timescale 1ns/1ps
module rmsa_core_model (
    input wire logic clk, // core clock
    output logic acc_valid, // address present
    output logic xlate_en, // translation on
    output logic [31:0] acc_addr // effective address
);
    initial
    begin
        acc_valid = 0;
        xlate_en = 0;
        acc_addr = 32'h0;
    end
    // alternate region ends so the low address bits never pick the bit
    task automatic issue(input logic [4:0] n, input logic x);
        @(negedge clk);
        acc_valid = 1;
        xlate_en = x;
        acc_addr = {n, {27{n[0]}}};
        @(negedge clk);
        acc_valid = 0;
        xlate_en = 0;
        acc_addr = ~acc_addr;
    endtask : issue
endmodule : rmsa_core_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rmsa_pkg::*;
    logic clk = 0, sys_rst = 1, spr_valid = 0, spr_ack_r, acc_valid, xlate_en;
    rmsa_spr_req_t spr_req = '0;
    logic [31:0] spr_rdata_r, acc_addr;
    rmsa_attr_t attr_r;
    int bad_count = 0, comparisons = 0, cyc = 0;
    logic [31:0] pat [3] = '{32'ha5c3_0f81, 32'h5a3c_f07e, 32'h0ff0_1234};
    logic [9:0] num [3] = '{RMSA_SPR_GUARD, RMSA_SPR_ENDIAN, RMSA_SPR_COMPRESS};
    rmsa_top dut (.clk(clk), .sys_rst(sys_rst), .spr_valid(spr_valid), .spr_req(spr_req),
        .spr_ack_r(spr_ack_r), .spr_rdata_r(spr_rdata_r), .acc_valid(acc_valid),
        .xlate_en(xlate_en), .acc_addr(acc_addr), .attr_r(attr_r));
    rmsa_core_model core (.clk(clk), .acc_valid(acc_valid), .xlate_en(xlate_en), .acc_addr(acc_addr));
    initial
        forever #12.5 clk = ~clk;
    task automatic summarize();
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic spr(input logic w, input logic [9:0] n, input logic [31:0] d, input logic a);
        @(negedge clk);
        spr_valid = 1;
        spr_req = '{w, n, d};
        @(negedge clk);
        spr_valid = 0;
        chk("ack", {31'h0, a}, {31'h0, spr_ack_r});
        if (!w)
            chk("rdata", d, spr_rdata_r);
    endtask : spr
    task automatic t_regs();
        for (int i = 0; i < 3; i++)
            spr(0, num[i], 32'h0, 1);
        for (int i = 0; i < 3; i++)
            spr(1, num[i], pat[i], 1);
        for (int i = 0; i < 3; i++)
            spr(0, num[i], pat[i], 1);
        // unmapped number must neither answer nor alias a real register
        spr(1, 10'h3ba, 32'hffff_ffff, 0);
        spr(0, 10'h3ba, 32'h0, 0);
        spr(0, num[0], pat[0], 1);
    endtask : t_regs
    task automatic t_lookup();
        for (int n = 0; n < 32; n++)
        begin
            core.issue(n[4:0], 0);
            // bits count from the msb: region n lives in bit 31 - n
            chk("attr", {28'h0, 1'b1, pat[0][31 - n], pat[1][31 - n], pat[2][31 - n]},
                {28'h0, attr_r});
        end
        core.issue(5'h1f, 1);
        chk("xlate", 32'h0, {28'h0, attr_r});
    endtask : t_lookup
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 0;
        t_regs();
        t_lookup();
        summarize();
    end
endmodule : tb_top
